/* tick_wdog.sv */
// periodic tick timer and watchdog of the clock and reset generator
// assumes an apb master on pclk; oscillator clock, debug and mode levels arrive asynchronously
//
// How it works
// - tick control write restarts tick period
// - prescale 000 stops tick, else 2^10..2^16
// - modulus multiplies prescale by value plus one
// - tick counts oscillator clock edges only
// - tick prescale resets to off
// - window mode: early service write resets part
// - window mode: repeat 55, AA restarts timeout
// - debug halt bit freezes both counters
// - rate 000 off, else 2^14..2^24 cycles
// - nonzero rate write starts timeout immediately
// - timeout without service asserts system reset
// - rate/window write once in normal mode
// - service register reads zero, writes anytime
// - service writes ignored while watchdog off
// - bad service value asserts system reset
// - 55 then AA restarts; repeats harmless except AA after a restart in window mode
// - timeout counts from last restart
// - factory registers writable only in special mode
// - tick interrupt gated by enable bit
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module tick_wdog
    import tick_wdog_pkg::*;
#(
    parameter int unsigned TIME_SHIFT_CUT = 0
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // asynchronous inputs
    input  wire logic              osc_clk_in,
    input  wire logic              debug_active,
    input  wire logic              special_mode,
    // outputs to the system
    output logic                   sys_reset_req,
    output logic                   tick_flag,
    output logic                   tick_irq
);

    state_s s_ff;
    state_s nxt_s;

    logic [IDX_W-1:0]      idx;
    logic                  setup;
    logic                  wr;
    logic                  mapped;
    logic                  osc_rise;
    logic                  halt;
    logic                  special;
    logic                  step;
    logic [2:0]            tick_pre;
    logic [4:0]            tick_shift;
    logic [TICK_CNT_W-1:0] tick_last;
    logic                  tick_set;
    logic [2:0]            wd_rate;
    logic                  wd_on;
    logic [4:0]            wd_shift;
    logic [WD_CNT_W-1:0]   wd_period;
    logic [WD_CNT_W-1:0]   wd_last;
    logic                  win_open;
    logic                  wd_ctrl_ok;
    logic                  svc_wr;
    logic                  bite;
    logic                  restart;
    logic [7:0]            wbyte;

    assign idx      = paddr[ADDR_W-1:2];
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & s_ff.pready & pwrite;
    assign wbyte    = pwdata[7:0];
    assign osc_rise = s_ff.osc_sync[1] & ~s_ff.osc_prev;
    assign special  = s_ff.spec_sync[1];
    assign halt     = s_ff.wd_ctrl[WD_DBG_BIT] & s_ff.dbg_sync[1];
    assign step     = osc_rise & ~halt;

    // tick period is modulus plus one, shifted by the prescale exponent
    assign tick_pre   = s_ff.tick_ctrl[TICK_PRE_HI:TICK_PRE_LO];
    assign tick_shift = 5'(tick_pre + TICK_SHIFT_BASE - 5'(TIME_SHIFT_CUT));
    assign tick_last  = TICK_CNT_W'((TICK_CNT_W'(s_ff.tick_ctrl[TICK_MOD_HI:TICK_MOD_LO]) + 1'b1)
                        << tick_shift) - 1'b1;

    // watchdog period and the window in its last quarter
    assign wd_rate   = s_ff.wd_ctrl[WD_RATE_HI:WD_RATE_LO];
    assign wd_on     = wd_rate != WD_RATE_OFF;
    assign wd_shift  = wd_on ? 5'(WD_SHIFT_TAB[wd_rate] - 5'(TIME_SHIFT_CUT)) : '0;
    assign wd_period = WD_CNT_W'(1) << wd_shift;
    assign wd_last   = wd_period - 1'b1;
    assign win_open  = s_ff.wd_cnt >= (wd_period - (wd_period >> 2));
    assign svc_wr    = wr & (idx == IDX_WDOG_SVC) & wd_on;
    assign wd_ctrl_ok = ~s_ff.wd_once | special;

    assign mapped = (idx == IDX_TICK_CTRL) | (idx == IDX_WDOG_CTRL) | (idx == IDX_TICK_STAT) |
                    (idx == IDX_TICK_IE) | (idx == IDX_FAC_BYP) | (idx == IDX_FAC_CLK) |
                    (idx == IDX_WDOG_SVC);

    always_comb begin
        nxt_s    = s_ff;
        tick_set = 1'b0;
        bite     = 1'b0;
        restart  = 1'b0;

        // two-stage synchronisers
        nxt_s.osc_sync  = {s_ff.osc_sync[0], osc_clk_in};
        nxt_s.osc_prev  = s_ff.osc_sync[1];
        nxt_s.dbg_sync  = {s_ff.dbg_sync[0], debug_active};
        nxt_s.spec_sync = {s_ff.spec_sync[0], special_mode};

        // apb: answer one cycle after setup
        nxt_s.pready  = setup;
        nxt_s.pslverr = setup & ~mapped;
        if (setup) begin
            nxt_s.prdata = '0;
            unique case (idx)
                IDX_TICK_CTRL: nxt_s.prdata[6:0] = s_ff.tick_ctrl;
                IDX_WDOG_CTRL: nxt_s.prdata[7:0] = s_ff.wd_ctrl;
                IDX_TICK_STAT: nxt_s.prdata[TICK_FLAG_BIT] = s_ff.tick_flag;
                IDX_TICK_IE:   nxt_s.prdata[TICK_IE_BIT] = s_ff.tick_ie;
                IDX_FAC_BYP:   nxt_s.prdata[7:0] = special ? s_ff.fac_byp : FAC_BYP_FIXED;
                IDX_FAC_CLK:   nxt_s.prdata[7:0] = special ? s_ff.fac_clk : FAC_CLK_FIXED;
                default:       nxt_s.prdata = '0;
            endcase
        end

        // tick divider chain
        if (tick_pre == TICK_PRE_OFF) begin
            nxt_s.tick_cnt = '0;
        end else if (step) begin
            if (s_ff.tick_cnt >= tick_last) begin
                nxt_s.tick_cnt = '0;
                tick_set       = 1'b1;
            end else begin
                nxt_s.tick_cnt = s_ff.tick_cnt + 1'b1;
            end
        end
        if (wr && idx == IDX_TICK_CTRL) begin
            nxt_s.tick_ctrl = pwdata[6:0];
            nxt_s.tick_cnt  = '0;
        end
        if (wr && idx == IDX_TICK_IE) begin
            nxt_s.tick_ie = pwdata[TICK_IE_BIT];
        end
        if (wr && idx == IDX_TICK_STAT && pwdata[TICK_FLAG_BIT]) begin
            nxt_s.tick_flag = 1'b0;
        end
        // a new tick wins over a clear in the same cycle
        if (tick_set) begin
            nxt_s.tick_flag = 1'b1;
        end
        nxt_s.tick_irq = nxt_s.tick_flag & nxt_s.tick_ie;

        // watchdog counter
        if (wd_on && step) begin
            if (s_ff.wd_cnt >= wd_last) begin
                bite = 1'b1;
            end else begin
                nxt_s.wd_cnt = s_ff.wd_cnt + 1'b1;
            end
        end

        // service sequence
        if (svc_wr) begin
            // in window mode any write before the window opens bites
            if (s_ff.wd_ctrl[WD_WIN_BIT] && !win_open) begin
                bite = 1'b1;
            end else if (wbyte == SVC_ARM) begin
                nxt_s.wd_armed = 1'b1;
            end else if (wbyte == SVC_FIRE) begin
                restart = s_ff.wd_armed;
            end else begin
                bite = 1'b1;
            end
        end

        // control writes
        if (wr && idx == IDX_WDOG_CTRL) begin
            if (wd_ctrl_ok) begin
                nxt_s.wd_ctrl[WD_WIN_BIT]            = pwdata[WD_WIN_BIT];
                nxt_s.wd_ctrl[WD_RATE_HI:WD_RATE_LO] = pwdata[WD_RATE_HI:WD_RATE_LO];
                nxt_s.wd_once                        = 1'b1;
                if (pwdata[WD_RATE_HI:WD_RATE_LO] != WD_RATE_OFF) begin
                    restart = 1'b1;
                end
            end
            if (!s_ff.dbg_once) begin
                nxt_s.wd_ctrl[WD_DBG_BIT] = pwdata[WD_DBG_BIT];
                nxt_s.dbg_once            = 1'b1;
            end
        end

        if (bite || restart) begin
            nxt_s.wd_cnt   = '0;
            nxt_s.wd_armed = 1'b0;
        end
        // a disabled watchdog holds its count at zero
        if (!wd_on && !restart) begin
            nxt_s.wd_cnt   = '0;
            nxt_s.wd_armed = 1'b0;
        end
        // one-cycle request; the system is expected to reset the block
        nxt_s.sys_reset = bite;

        // factory test registers
        if (wr && special && idx == IDX_FAC_BYP) begin
            nxt_s.fac_byp = wbyte;
        end
        if (wr && special && idx == IDX_FAC_CLK) begin
            nxt_s.fac_clk = wbyte;
        end
    end

    // the whole state sits in one register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata        = s_ff.prdata;
    assign pready        = s_ff.pready;
    assign pslverr       = s_ff.pslverr;
    assign sys_reset_req = s_ff.sys_reset;
    assign tick_flag     = s_ff.tick_flag;
    assign tick_irq      = s_ff.tick_irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_tick_write_restart: assert property (
        wr && idx == IDX_TICK_CTRL |=> s_ff.tick_cnt == '0 ##1 s_ff.tick_cnt <= TICK_CNT_W'(1))
        else $error("tick counter not restarted by control write");

    a_tick_off_idle: assert property (
        tick_pre == TICK_PRE_OFF && !wr |=> s_ff.tick_cnt == '0 && !tick_set)
        else $error("tick counts while prescale is off");

    a_tick_osc_only: assert property (
        !step && !wr && tick_pre != TICK_PRE_OFF |=> $stable(s_ff.tick_cnt))
        else $error("tick counter moved without oscillator edge");

    a_tick_period_flag: assert property (
        step && tick_pre != TICK_PRE_OFF && s_ff.tick_cnt == tick_last && !wr
        |=> tick_flag && s_ff.tick_cnt == '0)
        else $error("tick period end did not set flag");

    a_debug_halt_freeze: assert property (
        halt && !wr && !svc_wr |=> $stable(s_ff.wd_cnt) && $stable(s_ff.tick_cnt))
        else $error("counters moved during debug halt");

    a_timeout_bites: assert property (
        wd_on && step && s_ff.wd_cnt == wd_last |=> sys_reset_req ##1 (!sys_reset_req || $past(bite)))
        else $error("timeout did not request system reset");

    a_window_early_bite: assert property (
        svc_wr && s_ff.wd_ctrl[WD_WIN_BIT] && !win_open |=> sys_reset_req && s_ff.wd_cnt == '0)
        else $error("early service write in window mode not punished");

    a_bad_value_bite: assert property (
        svc_wr && wbyte != SVC_ARM && wbyte != SVC_FIRE |=> sys_reset_req)
        else $error("bad service value did not reset");

    a_off_svc_ignored: assert property (
        wr && idx == IDX_WDOG_SVC && !wd_on && !(wd_on && step) |=> !sys_reset_req)
        else $error("service write acted while watchdog off");

    a_pair_restarts: assert property (
        svc_wr && wbyte == SVC_FIRE && s_ff.wd_armed && (!s_ff.wd_ctrl[WD_WIN_BIT] || win_open)
        |=> s_ff.wd_cnt == '0 && !s_ff.wd_armed && !sys_reset_req)
        else $error("service pair did not restart timeout");

    a_rate_write_start: assert property (
        wr && idx == IDX_WDOG_CTRL && wd_ctrl_ok && pwdata[WD_RATE_HI:WD_RATE_LO] != WD_RATE_OFF
        |=> s_ff.wd_cnt == '0 && wd_on)
        else $error("nonzero rate write did not start timeout");

    a_once_lock: assert property (
        wr && idx == IDX_WDOG_CTRL && s_ff.wd_once && !special |=> $stable(wd_rate))
        else $error("locked watchdog rate changed");

    a_svc_reads_zero: assert property (
        setup && idx == IDX_WDOG_SVC |=> pready && prdata == '0)
        else $error("service register read not zero");

    a_fac_fixed_read: assert property (
        setup && idx == IDX_FAC_CLK && !special |=> prdata == DATA_W'(FAC_CLK_FIXED))
        else $error("factory register read not fixed outside special mode");

    a_irq_gate: assert property (
        tick_set && s_ff.tick_ie && !(wr && idx == IDX_TICK_IE) |=> tick_irq)
        else $error("tick interrupt not raised");

    // counter steps, write locks and factory registers
    a_tick_write_value: assert property (
        wr && idx == IDX_TICK_CTRL |=> s_ff.tick_ctrl == $past(pwdata[TICK_PRE_HI:TICK_MOD_LO]))
        else $error("tick control write not stored");

    a_tick_count_step: assert property (
        step && tick_pre != TICK_PRE_OFF && s_ff.tick_cnt < tick_last && !wr
        |=> s_ff.tick_cnt == $past(s_ff.tick_cnt) + 1'b1)
        else $error("tick counter did not advance on oscillator edge");

    a_wd_count_step: assert property (
        wd_on && step && s_ff.wd_cnt < wd_last && !wr
        |=> s_ff.wd_cnt == $past(s_ff.wd_cnt) + 1'b1)
        else $error("watchdog counter did not advance on oscillator edge");

    a_wd_off_idle: assert property (
        !wd_on && !wr |=> s_ff.wd_cnt == '0 && !sys_reset_req)
        else $error("disabled watchdog counted or reset");

    a_arm_sets: assert property (
        svc_wr && wbyte == SVC_ARM && (!s_ff.wd_ctrl[WD_WIN_BIT] || win_open)
        && !(step && s_ff.wd_cnt >= wd_last) |=> s_ff.wd_armed && !sys_reset_req)
        else $error("arming write not accepted");

    a_fire_unarmed: assert property (
        svc_wr && wbyte == SVC_FIRE && !s_ff.wd_armed && (!s_ff.wd_ctrl[WD_WIN_BIT] || win_open)
        && !(step && s_ff.wd_cnt >= wd_last) |=> !sys_reset_req && !s_ff.wd_armed)
        else $error("unarmed second service write not harmless");

    a_bite_zeroes_count: assert property (
        sys_reset_req |-> s_ff.wd_cnt == '0 && !s_ff.wd_armed)
        else $error("watchdog count not restarted by reset request");

    a_dbg_once_lock: assert property (
        wr && idx == IDX_WDOG_CTRL && s_ff.dbg_once |=> $stable(s_ff.wd_ctrl[WD_DBG_BIT]))
        else $error("locked debug halt bit changed");

    a_win_once_lock: assert property (
        wr && idx == IDX_WDOG_CTRL && s_ff.wd_once && !special |=> $stable(s_ff.wd_ctrl[WD_WIN_BIT]))
        else $error("locked window mode bit changed");

    a_special_ctrl_write: assert property (
        wr && idx == IDX_WDOG_CTRL && special |=> wd_rate == $past(pwdata[WD_RATE_HI:WD_RATE_LO]))
        else $error("rate write refused in special mode");

    a_fac_byp_guard: assert property (
        wr && idx == IDX_FAC_BYP && !special |=> $stable(s_ff.fac_byp))
        else $error("factory bypass register written outside special mode");

    a_fac_clk_guard: assert property (
        wr && idx == IDX_FAC_CLK && !special |=> $stable(s_ff.fac_clk))
        else $error("factory clock register written outside special mode");

    a_fac_byp_fixed: assert property (
        setup && idx == IDX_FAC_BYP && !special |=> prdata == DATA_W'(FAC_BYP_FIXED))
        else $error("factory bypass read not fixed outside special mode");

    a_irq_off: assert property (
        !s_ff.tick_ie && !(wr && idx == IDX_TICK_IE) |=> !tick_irq)
        else $error("tick interrupt raised while disabled");

    a_rate_off_write: assert property (
        wr && idx == IDX_WDOG_CTRL && wd_ctrl_ok && pwdata[WD_RATE_HI:WD_RATE_LO] == WD_RATE_OFF
        |=> !wd_on ##1 s_ff.wd_cnt == '0)
        else $error("rate write of zero did not stop watchdog");

endmodule : tick_wdog

/* tick_wdog_pkg.sv */
// constants, register map and state layout of the periodic tick and watchdog block
// assumes a 32-bit apb slave port with one register per aligned word
package tick_wdog_pkg;

    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int IDX_W      = 10;
    localparam int TICK_CNT_W = 21;
    localparam int WD_CNT_W   = 25;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_TICK_CTRL = 10'h001;
    localparam logic [IDX_W-1:0] IDX_WDOG_CTRL = 10'h002;
    localparam logic [IDX_W-1:0] IDX_TICK_STAT = 10'h003;
    localparam logic [IDX_W-1:0] IDX_TICK_IE   = 10'h004;
    localparam logic [IDX_W-1:0] IDX_FAC_BYP   = 10'h009;
    localparam logic [IDX_W-1:0] IDX_FAC_CLK   = 10'h00A;
    localparam logic [IDX_W-1:0] IDX_WDOG_SVC  = 10'h00B;

    // field positions
    localparam int TICK_PRE_HI = 6;
    localparam int TICK_PRE_LO = 4;
    localparam int TICK_MOD_HI = 3;
    localparam int TICK_MOD_LO = 0;
    localparam int WD_WIN_BIT  = 7;
    localparam int WD_DBG_BIT  = 6;
    localparam int WD_RATE_HI  = 2;
    localparam int WD_RATE_LO  = 0;
    localparam int TICK_FLAG_BIT = 0;
    localparam int TICK_IE_BIT   = 0;

    // values
    localparam logic [6:0] TICK_CTRL_RST = 7'h00;
    localparam logic [7:0] WD_CTRL_RST   = 8'h00;
    localparam logic [2:0] TICK_PRE_OFF  = 3'h0;
    localparam logic [2:0] WD_RATE_OFF   = 3'h0;
    localparam logic [7:0] SVC_ARM       = 8'h55;
    localparam logic [7:0] SVC_FIRE      = 8'hAA;
    localparam logic [7:0] FAC_BYP_FIXED = 8'h00;
    localparam logic [7:0] FAC_CLK_FIXED = 8'h80;
    localparam logic [7:0] FAC_BYP_RST   = 8'h00;
    localparam logic [7:0] FAC_CLK_RST   = 8'h80;

    // tick period = (modulus + 1) << (prescale + TICK_SHIFT_BASE - TIME_SHIFT_CUT)
    localparam logic [4:0] TICK_SHIFT_BASE = 5'h09;
    // watchdog timeout exponents for rate codes 7 down to 1
    localparam logic [7:1][4:0] WD_SHIFT_TAB = {5'h18, 5'h17, 5'h16, 5'h14, 5'h12, 5'h10, 5'h0E};

    typedef struct packed {
        logic [1:0]            osc_sync;
        logic                  osc_prev;
        logic [1:0]            dbg_sync;
        logic [1:0]            spec_sync;
        logic [6:0]            tick_ctrl;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic                  tick_flag;
        logic                  tick_ie;
        logic                  tick_irq;
        logic [7:0]            wd_ctrl;
        logic                  wd_once;
        logic                  dbg_once;
        logic [WD_CNT_W-1:0]   wd_cnt;
        logic                  wd_armed;
        logic                  sys_reset;
        logic [7:0]            fac_byp;
        logic [7:0]            fac_clk;
        logic                  pready;
        logic                  pslverr;
        logic [DATA_W-1:0]     prdata;
    } state_s;

    localparam state_s STATE_RST = '{
        tick_ctrl: TICK_CTRL_RST,
        wd_ctrl:   WD_CTRL_RST,
        fac_byp:   FAC_BYP_RST,
        fac_clk:   FAC_CLK_RST,
        default:   '0
    };

endpackage : tick_wdog_pkg

/* tick_wdog_tb.sv */
// self-checking bench for tick_wdog: apb registers, tick periods, watchdog service and bites
// assumes TIME_SHIFT_CUT of 8 and an oscillator clock at a quarter of pclk
`timescale 1ns/10ps
module tick_wdog_tb;
    import tick_wdog_pkg::*;

    logic              pclk         = 1'b0;
    logic              presetn      = 1'b0;
    logic [ADDR_W-1:0] paddr        = '0;
    logic              psel         = 1'b0;
    logic              penable      = 1'b0;
    logic              pwrite       = 1'b0;
    logic [DATA_W-1:0] pwdata       = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              osc_clk_in   = 1'b0;
    logic              debug_active = 1'b0;
    logic              special_mode = 1'b0;
    logic              sys_reset_req;
    logic              tick_flag;
    logic              tick_irq;
    logic [1:0]        osc_div      = '0;
    int                failures     = 0;
    int                total_checks = 0;
    int                bites        = 0;

    tick_wdog #(.TIME_SHIFT_CUT(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_clk_in(osc_clk_in), .debug_active(debug_active), .special_mode(special_mode),
        .sys_reset_req(sys_reset_req), .tick_flag(tick_flag), .tick_irq(tick_irq)
    );

    always #4 pclk = ~pclk;

    // oscillator at pclk/4 and a tally of reset request pulses
    always @(posedge pclk) begin
        osc_div    <= osc_div + 2'd1;
        osc_clk_in <= osc_div[1];
        if (sys_reset_req === 1'b1) begin
            bites <= bites + 1;
        end
    end

    task automatic print_verdict;
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic apb(input logic [IDX_W-1:0] idx, input logic wr_en, input logic [7:0] d,
                       output logic [DATA_W-1:0] rd, output logic err);
        int n;
        @(posedge pclk);
        paddr   <= {idx, 2'b00};
        pwrite  <= wr_en;
        pwdata  <= {24'h000000, d};
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            $display("unexpected pready: expected 1 seen %b", pready);
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(idx, 1'b1, d, r, e);
    endtask : wr

    task automatic rd_chk(input string what, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(idx, 1'b0, 8'h00, r, e);
        chk(what, exp, r);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask : rd_chk

    task automatic wait_flag(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tick_flag !== 1'b1 && n < 3000);
        if (tick_flag !== 1'b1) begin
            failures++;
            $display("unexpected tick_flag: expected 1 seen %b", tick_flag);
            print_verdict();
        end
    endtask : wait_flag

    task automatic wait_bite(output int n);
        int b0;
        b0 = bites;
        n  = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (bites == b0 && n < 3000);
        if (bites == b0) begin
            failures++;
            $display("unexpected sys_reset_req: expected pulse seen none");
            print_verdict();
        end
    endtask : wait_bite

    task automatic t_reset;
        logic [DATA_W-1:0] r;
        logic              e;
        rd_chk("tick ctrl", IDX_TICK_CTRL, 32'h0);
        rd_chk("wdog ctrl", IDX_WDOG_CTRL, 32'h0);
        rd_chk("fac byp", IDX_FAC_BYP, 32'h0);
        rd_chk("fac clk", IDX_FAC_CLK, 32'h80);
        rd_chk("svc", IDX_WDOG_SVC, 32'h0);
        apb(10'h3FF, 1'b0, 8'h00, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        idle(300);
        chk("tick off", 32'h0, {31'h0, tick_flag});
    endtask : t_reset

    task automatic t_tick;
        int pre_t[3] = '{1, 1, 2};
        int mod_t[3] = '{1, 15, 2};
        int n;
        int per;
        for (int i = 0; i < 3; i++) begin
            per = ((mod_t[i] + 1) << (pre_t[i] + 1)) * 4;
            wr(IDX_TICK_CTRL, {1'b0, 3'(pre_t[i]), 4'(mod_t[i])});
            idle(per / 2);
            wr(IDX_TICK_CTRL, {1'b0, 3'(pre_t[i]), 4'(mod_t[i])});
            wr(IDX_TICK_STAT, 8'h01);
            wait_flag(n);
            chk_rng("tick restart", per - 8, per + 8, n);
            wr(IDX_TICK_STAT, 8'h01);
            wait_flag(n);
            chk_rng("tick reload", per - 8, per + 8, n);
        end
        wr(IDX_TICK_IE, 8'h01);
        idle(2);
        chk("irq on", 32'h1, {31'h0, tick_irq});
        wr(IDX_TICK_IE, 8'h00);
        idle(2);
        chk("irq off", 32'h0, {31'h0, tick_irq});
    endtask : t_tick

    task automatic t_debug;
        int n;
        int b0;
        wr(IDX_WDOG_CTRL, 8'h41);
        @(posedge pclk);
        debug_active <= 1'b1;
        idle(8);
        wr(IDX_TICK_STAT, 8'h01);
        b0 = bites;
        idle(600);
        chk("halted bites", b0, bites);
        chk("halted tick", 32'h0, {31'h0, tick_flag});
        debug_active <= 1'b0;
        wait_flag(n);
        chk_rng("tick resumes", 1, 110, n);
        wr(IDX_WDOG_SVC, SVC_ARM);
        wr(IDX_WDOG_SVC, SVC_FIRE);
    endtask : t_debug

    task automatic t_service;
        int n;
        int b0;
        b0 = bites;
        for (int i = 0; i < 4; i++) begin
            idle(150);
            wr(IDX_WDOG_SVC, SVC_ARM);
            wr(IDX_WDOG_SVC, SVC_ARM);
            wr(IDX_TICK_STAT, 8'h01);
            wr(IDX_WDOG_SVC, SVC_FIRE);
            wr(IDX_WDOG_SVC, SVC_FIRE);
        end
        chk("serviced bites", b0, bites);
        wait_bite(n);
        chk_rng("timeout", 248, 268, n);
        wait_bite(n);
        chk_rng("timeout after bite", 248, 266, n);
        wr(IDX_WDOG_CTRL, 8'h00);
        rd_chk("wdog locked", IDX_WDOG_CTRL, 32'h41);
        wr(IDX_WDOG_SVC, 8'h12);
        wait_bite(n);
        chk_rng("bad value", 1, 6, n);
        wr(IDX_FAC_BYP, 8'h33);
        rd_chk("fac byp user", IDX_FAC_BYP, 32'h0);
    endtask : t_service

    task automatic t_special;
        int n;
        int b0;
        @(posedge pclk);
        special_mode <= 1'b1;
        idle(4);
        wr(IDX_WDOG_CTRL, 8'h81);
        rd_chk("wdog special", IDX_WDOG_CTRL, 32'hC1);
        wr(IDX_WDOG_SVC, SVC_ARM);
        wait_bite(n);
        chk_rng("early service", 1, 6, n);
        idle(205);
        wr(IDX_WDOG_SVC, SVC_ARM);
        wr(IDX_WDOG_SVC, SVC_FIRE);
        b0 = bites;
        idle(120);
        chk("window service", b0, bites);
        wr(IDX_WDOG_SVC, SVC_ARM);
        wait_bite(n);
        chk_rng("before next window", 1, 6, n);
        wr(IDX_FAC_BYP, 8'h5A);
        rd_chk("fac byp special", IDX_FAC_BYP, 32'h5A);
        wr(IDX_WDOG_CTRL, 8'h80);
        wr(IDX_WDOG_SVC, 8'h12);
        b0 = bites;
        idle(400);
        chk("disabled bites", b0, bites);
    endtask : t_special

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tick();
        t_debug();
        t_service();
        t_special();
        print_verdict();
    end

endmodule : tick_wdog_tb
